// [common/temp_regs_pkg.sv]
// register map, field layout and reset values of the sensor register bank
// assumes: pointer index is the low four bits of the host pointer byte
package temp_regs_pkg;
  localparam int         DATA_W         = 16;
  localparam int         PTR_W          = 4;
  localparam int         TEMP_W         = 13;
  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_RESERVED   = 4'h0;
  localparam logic [3:0] IDX_SETUP      = 4'h1;
  localparam logic [3:0] IDX_HIGH       = 4'h2;
  localparam logic [3:0] IDX_LOW        = 4'h3;
  localparam logic [3:0] IDX_CRIT       = 4'h4;
  localparam logic [3:0] IDX_AMBIENT    = 4'h5;
  localparam logic [3:0] IDX_MAKER      = 4'h6;
  localparam logic [3:0] IDX_PART       = 4'h7;
  localparam logic [3:0] IDX_RES        = 4'h8;
  // ----------------------------------------------------------------
  // setup word fields
  // ----------------------------------------------------------------
  localparam int         HYST_HI        = 10;
  localparam int         HYST_LO        = 9;
  localparam int         SHUTDOWN_SELECT_BIT       = 8;
  localparam int         CRIT_LOCK_BIT  = 7;
  localparam int         WIN_LOCK_BIT   = 6;
  localparam int         INT_CLR_BIT    = 5;
  localparam int         ALT_STAT_BIT   = 4;
  localparam int         ALT_CNT_BIT    = 3;
  localparam int         ALT_SEL_BIT    = 2;
  localparam int         ALT_POL_BIT    = 1;
  localparam int         ALT_MOD_BIT    = 0;
  // ----------------------------------------------------------------
  // ambient word fields and masks
  // ----------------------------------------------------------------
  localparam int         AMB_CRIT_BIT   = 15;
  localparam int         AMB_HIGH_BIT   = 14;
  localparam int         AMB_LOW_BIT    = 13;
  localparam logic [15:0] LIMIT_MASK    = 16'h1FFC;
  localparam logic [7:0]  RES_MASK      = 8'h03;
  // ----------------------------------------------------------------
  // reset and fixed read values
  // ----------------------------------------------------------------
  localparam logic [15:0] RESERVED_VAL  = 16'h001F;
  localparam logic [15:0] ZERO_WORD     = 16'h0000;
  localparam logic [15:0] LIMIT_RST     = 16'h0000;
  localparam logic [1:0]  HYST_RST      = 2'h0;
  localparam logic [7:0]  RES_RST       = 8'h03;
endpackage : temp_regs_pkg

// [hdl/temp_sensor_register_bank.sv]
// user register bank of a digital temperature sensor
// assumes: serial engine delivers pointer, write and read strobes as one-cycle
// pulses synchronous to clk_sys; converter delivers one pulse per period
//
// Contract
// (RULE1) one 16-bit setup word, low eleven bits hold user settings
// (RULE2) setup bits 10:9 select hysteresis for window comparisons
// (RULE3) setup bit 8 picks continuous conversion or shutdown
// (RULE4) in shutdown no new conversion, ambient keeps last value
// (RULE5) bits 7 and 6 lock critical limit and window limits
// (RULE6) lock bits cannot be cleared by writes, only by reset
// (RULE7) setup bits 5:0 configure the alert output
// (RULE8) a setup bit picks window-plus-critical or critical-only alert
// (RULE9) limits hold sign bit 12, magnitude 11:2; other bits zero
// (RULE10) ambient flags bits 15:13, sign 12, magnitude 11:0
// (RULE11) setup bits 15:11 read zero and ignore writes
// (RULE12) host writes 8-bit pointer, index low nibble, high nibble zero
// (RULE13) ambient double-buffered, refreshed once per conversion
// (RULE14) reads and writes still work during shutdown
`timescale 1ns/10ps
`default_nettype none
module temp_sensor_register_bank
  import temp_regs_pkg::*;
#(
  parameter logic [15:0] MAKER_ID = 16'h0A5A,  // arbitrary value
  parameter logic [15:0] PART_REV = 16'h0C01   // arbitrary value
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire logic              ptr_wr,
  input  wire logic [7:0]        ptr_byte,
  input  wire logic              wr_en,
  input  wire logic [15:0]       wr_data,
  input  wire logic              rd_en,
  input  wire logic              conv_valid,
  input  wire logic [12:0]       conv_temp,
  input  wire logic              alert_status,
  output logic [15:0]            rd_data_reg,
  output logic                   rd_valid_reg,
  output logic [1:0]             limit_hysteresis_reg,
  output logic                   shutdown_select_reg,
  output logic [5:0]             alert_cfg_reg,
  output logic                   int_clear_reg,
  output logic [1:0]             resolution_reg
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [3:0]  ptr_reg,   ptr_next;
  logic [15:0] high_reg,  high_next;
  logic [15:0] low_reg,   low_next;
  logic [15:0] crit_reg,  crit_next;
  logic [15:0] amb_reg,   amb_next;
  logic [1:0]  hyst_next;
  logic        shutdown_select_next;
  logic        crit_lock_reg, crit_lock_next;
  logic        win_lock_reg,  win_lock_next;
  logic [5:0]  alert_next;
  logic        int_clr_next;
  logic [1:0]  res_next;
  logic [15:0] rd_next;
  logic        rd_valid_next;
  logic [15:0] setup_view;
  logic [15:0] rd_mux;
  logic        any_lock;
  logic        wr_setup;
  logic signed [12:0] t_now, t_high, t_low, t_crit;

  assign any_lock = crit_lock_reg | win_lock_reg;
  assign wr_setup = wr_en && (ptr_reg == IDX_SETUP);

  // ----------------------------------------------------------------
  // read view and read mux
  // ----------------------------------------------------------------
  // (RULE1) 16-bit setup view
  // (RULE11) upper setup bits tied to zero
  always_comb begin
    setup_view                      = ZERO_WORD;
    setup_view[HYST_HI:HYST_LO]     = limit_hysteresis_reg;
    setup_view[SHUTDOWN_SELECT_BIT]            = shutdown_select_reg;
    setup_view[CRIT_LOCK_BIT]       = crit_lock_reg;
    setup_view[WIN_LOCK_BIT]        = win_lock_reg;
    setup_view[ALT_STAT_BIT]        = alert_status;
    setup_view[ALT_CNT_BIT]         = alert_cfg_reg[ALT_CNT_BIT];
    setup_view[ALT_SEL_BIT]         = alert_cfg_reg[ALT_SEL_BIT];
    setup_view[ALT_POL_BIT]         = alert_cfg_reg[ALT_POL_BIT];
    setup_view[ALT_MOD_BIT]         = alert_cfg_reg[ALT_MOD_BIT];
  end

  // unmapped indices read as zero
  always_comb begin
    case (ptr_reg)
      IDX_RESERVED: rd_mux = RESERVED_VAL;
      IDX_SETUP:    rd_mux = setup_view;
      IDX_HIGH:     rd_mux = high_reg;
      IDX_LOW:      rd_mux = low_reg;
      IDX_CRIT:     rd_mux = crit_reg;
      IDX_AMBIENT:  rd_mux = amb_reg;
      IDX_MAKER:    rd_mux = MAKER_ID;
      IDX_PART:     rd_mux = PART_REV;
      IDX_RES:      rd_mux = {8'h00, 6'h00, resolution_reg};
      default:      rd_mux = ZERO_WORD;
    endcase
  end

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  // limits and reading share one 1/16 degree scale for comparison
  assign t_now  = $signed(conv_temp);
  assign t_high = $signed(high_reg[12:0]);
  assign t_low  = $signed(low_reg[12:0]);
  assign t_crit = $signed(crit_reg[12:0]);

  always_comb begin
    ptr_next       = ptr_reg;
    high_next      = high_reg;
    low_next       = low_reg;
    crit_next      = crit_reg;
    amb_next       = amb_reg;
    hyst_next      = limit_hysteresis_reg;
    shutdown_select_next      = shutdown_select_reg;
    crit_lock_next = crit_lock_reg;
    win_lock_next  = win_lock_reg;
    alert_next     = alert_cfg_reg;
    int_clr_next   = 1'b0;
    res_next       = resolution_reg;
    rd_next        = rd_data_reg;
    rd_valid_next  = 1'b0;
    // upper pointer nibble is the host's to keep zero; it is ignored here
    if (ptr_wr) begin
      ptr_next = ptr_byte[PTR_W-1:0];
    end
    // (RULE14) writes accepted regardless of shutdown
    if (wr_en) begin
      case (ptr_reg)
        IDX_SETUP: begin
          // (RULE2) hysteresis frozen while locked
          if (!any_lock) begin
            hyst_next = wr_data[HYST_HI:HYST_LO];
          end
          // (RULE3) shutdown may always clear, set only when unlocked
          if (!wr_data[SHUTDOWN_SELECT_BIT] || !any_lock) begin
            shutdown_select_next = wr_data[SHUTDOWN_SELECT_BIT];
          end
          // (RULE6) locks only ever set by a write
          crit_lock_next = crit_lock_reg | wr_data[CRIT_LOCK_BIT];
          win_lock_next  = win_lock_reg | wr_data[WIN_LOCK_BIT];
          // (RULE7) alert config; clear bit is a pulse, status read-only
          int_clr_next                = wr_data[INT_CLR_BIT];
          alert_next[ALT_CNT_BIT]     = wr_data[ALT_CNT_BIT];
          // (RULE8) alert source select
          alert_next[ALT_SEL_BIT]     = wr_data[ALT_SEL_BIT];
          alert_next[ALT_POL_BIT]     = wr_data[ALT_POL_BIT];
          alert_next[ALT_MOD_BIT]     = wr_data[ALT_MOD_BIT];
        end
        // (RULE5) window and critical limits blocked by their lock
        // (RULE9) limit bits masked
        IDX_HIGH: if (!win_lock_reg)  high_next = wr_data & LIMIT_MASK;
        IDX_LOW:  if (!win_lock_reg)  low_next  = wr_data & LIMIT_MASK;
        IDX_CRIT: if (!crit_lock_reg) crit_next = wr_data & LIMIT_MASK;
        IDX_RES:  res_next = wr_data[1:0] & RES_MASK[1:0];
        default: ;
      endcase
    end
    // (RULE4) shutdown holds the previous reading
    if (conv_valid && !shutdown_select_reg) begin
      // (RULE13) whole word replaced in one edge
      amb_next               = {3'h0, conv_temp};
      // (RULE10) limit flags on top
      amb_next[AMB_CRIT_BIT] = (t_now >= t_crit);
      amb_next[AMB_HIGH_BIT] = (t_now > t_high);
      amb_next[AMB_LOW_BIT]  = (t_now < t_low);
    end
    // (RULE13) the read word is captured whole, never torn
    if (rd_en) begin
      rd_next       = rd_mux;
      rd_valid_next = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // ce low freezes everything, including pulse outputs
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ptr_reg              <= IDX_RESERVED;
      high_reg             <= LIMIT_RST;
      low_reg              <= LIMIT_RST;
      crit_reg             <= LIMIT_RST;
      amb_reg              <= ZERO_WORD;
      limit_hysteresis_reg <= HYST_RST;
      shutdown_select_reg  <= 1'b0;
      crit_lock_reg        <= 1'b0;
      win_lock_reg         <= 1'b0;
      alert_cfg_reg        <= 6'h00;
      int_clear_reg        <= 1'b0;
      resolution_reg       <= RES_RST[1:0];
      rd_data_reg          <= ZERO_WORD;
      rd_valid_reg         <= 1'b0;
    end else if (ce) begin
      ptr_reg              <= ptr_next;
      high_reg             <= high_next;
      low_reg              <= low_next;
      crit_reg             <= crit_next;
      amb_reg              <= amb_next;
      limit_hysteresis_reg <= hyst_next;
      shutdown_select_reg  <= shutdown_select_next;
      crit_lock_reg        <= crit_lock_next;
      win_lock_reg         <= win_lock_next;
      alert_cfg_reg        <= alert_next;
      int_clear_reg        <= int_clr_next;
      resolution_reg       <= res_next;
      rd_data_reg          <= rd_next;
      rd_valid_reg         <= rd_valid_next;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_lock_stays_set: assert property (crit_lock_reg && win_lock_reg |=> crit_lock_reg && win_lock_reg) // RULE6
    else $error("lock bit cleared without reset");
  a_crit_write_blocked: assert property (ce && wr_en && ptr_reg == IDX_CRIT && crit_lock_reg |=> $stable(crit_reg)) // RULE5
    else $error("critical limit changed while locked");
  a_win_write_blocked: assert property (ce && wr_en && ptr_reg == IDX_HIGH && win_lock_reg |=> $stable(high_reg)) // RULE5
    else $error("window limit changed while locked");
  a_limit_write_taken: assert property (ce && wr_en && ptr_reg == IDX_LOW && !win_lock_reg
      |=> low_reg == ($past(wr_data) & LIMIT_MASK)) // RULE9
    else $error("low limit not stored with mask");
  a_reading_held: assert property (ce && conv_valid && shutdown_select_reg && !rst_n == 1'b0 |=> $stable(amb_reg)) // RULE4
    else $error("reading updated during shutdown");
  a_reading_loaded: assert property (ce && conv_valid && !shutdown_select_reg |=> amb_reg[12:0] == $past(conv_temp)) // RULE10
    else $error("reading not loaded");
  a_shutdown_select_set_locked: assert property (ce && wr_setup && any_lock && !shutdown_select_reg |=> !shutdown_select_reg) // RULE3
    else $error("shutdown set while locked");
  a_hyst_frozen: assert property (ce && wr_setup && any_lock |=> $stable(limit_hysteresis_reg)) // RULE2
    else $error("hysteresis changed while locked");
  a_setup_upper_zero: assert property (ce && rd_en && ptr_reg == IDX_SETUP |=> rd_valid_reg && rd_data_reg[15:11] == 5'h00) // RULE11
    else $error("setup upper bits not zero");
  a_alert_cfg_write: assert property (ce && wr_setup |=> alert_cfg_reg[ALT_SEL_BIT] == $past(wr_data[ALT_SEL_BIT])
      && int_clear_reg == $past(wr_data[INT_CLR_BIT]) ##1 (!$past(ce) || !int_clear_reg || $past(wr_setup))) // RULE8
    else $error("alert config not stored");
  a_crit_write_shutdown_select: assert property (ce && wr_en && ptr_reg == IDX_CRIT && !crit_lock_reg && shutdown_select_reg
      |=> crit_reg == ($past(wr_data) & LIMIT_MASK)) // RULE14
    else $error("write refused during shutdown");

  c_lock_then_write: cover property (crit_lock_reg ##1 ce && wr_en && ptr_reg == IDX_CRIT);
  c_shutdown_conv:   cover property (shutdown_select_reg && ce && conv_valid);
  c_read_ambient:    cover property (ce && rd_en && ptr_reg == IDX_AMBIENT ##1 rd_valid_reg);
endmodule : temp_sensor_register_bank
`default_nettype wire

// [tb/host_model.sv]
// host-side model: pointer, write and read strobes toward the register bank
// assumes: bank samples every strobe on the rising edge of clk_sys
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic        clk_sys,
  input  wire logic [15:0] rd_data_reg,
  input  wire logic        rd_valid_reg,
  output var  logic        ptr_wr,
  output var  logic [7:0]  ptr_byte,
  output var  logic        wr_en,
  output var  logic [15:0] wr_data,
  output var  logic        rd_en
);
  // idle bus at time zero
  initial begin
    ptr_wr   = 1'b0;
    ptr_byte = 8'h00;
    wr_en    = 1'b0;
    wr_data  = 16'h0000;
    rd_en    = 1'b0;
  end

  // released data lines flip so stale values never look valid
  task set_ptr(input logic [3:0] idx);
    @(posedge clk_sys);
    ptr_wr   <= 1'b1;
    ptr_byte <= {4'h0, idx};
    @(posedge clk_sys);
    ptr_wr   <= 1'b0;
    ptr_byte <= ~{4'h0, idx};
  endtask : set_ptr

  task write_reg(input logic [3:0] idx, input logic [15:0] data);
    set_ptr(idx);
    wr_en   <= 1'b1;
    wr_data <= data;
    @(posedge clk_sys);
    wr_en   <= 1'b0;
    wr_data <= ~data;
  endtask : write_reg

  // bounded wait for the read answer; ok stays low on a hang
  task read_reg(input logic [3:0] idx, output logic [15:0] data, output logic ok);
    ok   = 1'b0;
    data = 16'hXXXX;
    set_ptr(idx);
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    for (int n = 0; n < 4 && !ok; n++) begin
      @(posedge clk_sys);
      if (rd_valid_reg === 1'b1) begin
        data = rd_data_reg;
        ok   = 1'b1;
      end
    end
  endtask : read_reg
endmodule : host_model
`default_nettype wire

// [tb/temp_sensor_register_bank_bench.sv]
// self-checking bench for the sensor register bank
// assumes: host_model drives the strobes; bench drives converter and alert inputs
`timescale 1ns/10ps
`default_nettype none
module temp_sensor_register_bank_bench;
  import temp_regs_pkg::*;
  localparam logic [15:0] MAKER = 16'h0A5A;  // arbitrary value
  localparam logic [15:0] PART  = 16'h0C01;  // arbitrary value
  logic clk_sys, rst_n, ce, conv_valid, alert_status, ptr_wr, wr_en, rd_en, rd_valid_reg;
  logic shutdown_select_reg, int_clear_reg;
  logic [12:0] conv_temp;
  logic [7:0]  ptr_byte;
  logic [15:0] wr_data, rd_data_reg;
  logic [1:0]  limit_hysteresis_reg, resolution_reg;
  logic [5:0]  alert_cfg_reg;
  int          bad_count;
  int          checks;

  host_model host (.clk_sys(clk_sys), .rd_data_reg(rd_data_reg), .rd_valid_reg(rd_valid_reg),
    .ptr_wr(ptr_wr), .ptr_byte(ptr_byte), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en));
  temp_sensor_register_bank #(.MAKER_ID(MAKER), .PART_REV(PART)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .ce(ce), .ptr_wr(ptr_wr), .ptr_byte(ptr_byte), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en),
    .conv_valid(conv_valid), .conv_temp(conv_temp), .alert_status(alert_status),
    .rd_data_reg(rd_data_reg), .rd_valid_reg(rd_valid_reg), .limit_hysteresis_reg(limit_hysteresis_reg),
    .shutdown_select_reg(shutdown_select_reg), .alert_cfg_reg(alert_cfg_reg),
    .int_clear_reg(int_clear_reg), .resolution_reg(resolution_reg));

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task summarize;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize

  task check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // a read that never answers counts as a mismatch; the run goes on to the verdict
  task rd_check(input logic [3:0] idx, input logic [15:0] exp);
    logic [15:0] d;
    logic        ok;
    host.read_reg(idx, d, ok);
    if (!ok) begin
      bad_count++;
      $display("[ERR] t=%0t read hang got=%h exp=%h", $time, d, exp);
    end else begin
      check(d, exp);
    end
  endtask : rd_check

  task conv(input logic [12:0] t);
    @(posedge clk_sys);
    conv_valid <= 1'b1;
    conv_temp  <= t;
    @(posedge clk_sys);
    conv_valid <= 1'b0;
    conv_temp  <= ~t;
  endtask : conv

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset_values;
    logic [15:0] exp [0:9];
    exp = '{RESERVED_VAL, ZERO_WORD, LIMIT_RST, LIMIT_RST, LIMIT_RST, ZERO_WORD, MAKER, PART, 16'h0003, ZERO_WORD};
    for (int i = 0; i < 10; i++) rd_check(4'(i), exp[i]);
    check({14'h0000, resolution_reg}, 16'h0003);
    $display("test reset_values done");
  endtask : t_reset_values

  task t_setup_fields;
    alert_status <= 1'b1;
    host.write_reg(IDX_SETUP, 16'hF83F);
    // clear pulse stands exactly one cycle after the write edge
    #1;
    check({15'h0000, int_clear_reg}, 16'h0001);
    @(posedge clk_sys);
    #1;
    check({15'h0000, int_clear_reg}, 16'h0000);
    rd_check(IDX_SETUP, 16'h001F);
    check({10'h000, alert_cfg_reg}, 16'h000F);
    host.write_reg(IDX_SETUP, 16'h0000);
    alert_status <= 1'b0;
    host.write_reg(IDX_RESERVED, 16'h0000);
    rd_check(IDX_RESERVED, RESERVED_VAL);
    host.write_reg(IDX_RES, 16'hFFFE);
    rd_check(IDX_RES, 16'h0002);
    $display("test setup_fields done");
  endtask : t_setup_fields

  task t_convert;
    logic [12:0] temps [0:2];
    logic [15:0] words [0:2];
    temps = '{13'h01A0, 13'h0320, 13'h1FF0};
    words = '{16'h41A0, 16'hC320, 16'h3FF0};
    host.write_reg(IDX_HIGH, 16'hFFFF);
    rd_check(IDX_HIGH, 16'h1FFC);
    host.write_reg(IDX_HIGH, 16'h0190);
    host.write_reg(IDX_LOW, 16'h0050);
    host.write_reg(IDX_CRIT, 16'h0320);
    for (int i = 0; i < 3; i++) begin
      conv(temps[i]);
      rd_check(IDX_AMBIENT, words[i]);
    end
    $display("test convert done");
  endtask : t_convert

  task t_shutdown;
    host.write_reg(IDX_SETUP, 16'h0700);
    // let the write edge settle before looking at the outputs
    #1;
    check({14'h0000, limit_hysteresis_reg}, 16'h0003);
    check({15'h0000, shutdown_select_reg}, 16'h0001);
    conv(13'h0123);
    rd_check(IDX_AMBIENT, 16'h3FF0);
    host.write_reg(IDX_LOW, 16'h1234);
    rd_check(IDX_LOW, 16'h1234);
    host.write_reg(IDX_SETUP, 16'h0000);
    $display("test shutdown done");
  endtask : t_shutdown

  task t_locks;
    host.write_reg(IDX_SETUP, 16'h00C0);
    host.write_reg(IDX_HIGH, 16'h0004);
    host.write_reg(IDX_LOW, 16'h0008);
    host.write_reg(IDX_CRIT, 16'h000C);
    rd_check(IDX_HIGH, 16'h0190);
    rd_check(IDX_LOW, 16'h1234);
    rd_check(IDX_CRIT, 16'h0320);
    host.write_reg(IDX_SETUP, 16'h0700);
    rd_check(IDX_SETUP, 16'h00C0);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_check(IDX_SETUP, 16'h0000);
    $display("test locks done");
  endtask : t_locks

  // pointer parked on resolution, so an unfrozen write would land there
  task t_ce_freeze;
    rd_check(IDX_RES, 16'h0003);
    ce <= 1'b0;
    host.write_reg(IDX_RES, 16'h0000);
    ce <= 1'b1;
    rd_check(IDX_RES, 16'h0003);
    $display("test ce_freeze done");
  endtask : t_ce_freeze

  // main sequence
  initial begin
    bad_count    = 0;
    checks       = 0;
    rst_n        = 1'b0;
    ce           = 1'b1;
    conv_valid   = 1'b0;
    conv_temp    = 13'h0000;
    alert_status = 1'b0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset_values();
    t_setup_fields();
    t_convert();
    t_shutdown();
    t_locks();
    t_ce_freeze();
    summarize();
  end
endmodule : temp_sensor_register_bank_bench
`default_nettype wire
